// ==== core/irq_one_flags.v ====
// first interrupt request: latched event flags, masks and request pin
//
// Operation
// - every flag stays set until software writes a one to its bit.
// - word 0x1800 bit 12 sets on a rising host port fault.
// - word 0x1800 bit 9 sets only on a rising main clock fail.
// - word 0x1800 bit 7 sets on a rising boot complete indication.
// - word 0x1801 bits 14, 13, 12 set on rising clock faults.
// - word 0x1801 bits 9 and 8 set on either edge of loop lock.
// - word 0x1801 bits 6 and 5 set only on rising reference loss.
// - word 0x1805 bits 9 and 8 set on each accessory detect event.
// - word 0x1805 bit 0 sets on rising headphone sense completion.
// - word 0x1806 jack rise/fall flags sit at bits 0/1, 2/3, 8/9.
// - clamp one flags at bits 4/5 and clamp two at bits 10/11.
// - the request is the or of all unmasked flags until every one is cleared, unless the global mask bit is set.
// - a masked input neither sets its flag nor drives the request.
// - after reset only boot complete is unmasked.
// - the request pin is active low by default.
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "irq_one_map.vh"

module irq_one_flags (
    // clock and reset
    input wire clk_sys_in,
    input wire reset_in,
    // avalon-mm slave
    input wire [15:0] address_in,
    input wire read_in,
    input wire write_in,
    input wire [3:0] byteenable_in,
    input wire [31:0] writedata_in,
    output wire [31:0] readdata_out,
    output wire waitrequest_out,
    // system and clock condition levels
    input wire host_port_fault_in,
    input wire main_clock_fail_in,
    input wire boot_complete_in,
    input wire processor_clock_fault_in,
    input wire second_clock_fault_in,
    input wire main_clock_fault_in,
    // loop status levels
    input wire loop_two_lock_in,
    input wire loop_one_lock_in,
    input wire loop_two_ref_missing_in,
    input wire loop_one_ref_missing_in,
    // accessory detector event strobes, same clock domain
    input wire accessory_two_detect_in,
    input wire accessory_one_detect_in,
    // headphone, jack and clamp levels
    input wire headphone_sense_in,
    input wire jack_one_in,
    input wire jack_two_in,
    input wire jack_three_in,
    input wire clamp_one_in,
    input wire clamp_two_in,
    // interrupt outputs
    output wire irq_out,
    output wire first_request_output_n_out
);

    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------
    // byte lanes 0 and 1 carry the 16-bit register data
    function [15:0] lane_mask;
        input [3:0] be;
        begin
            lane_mask = {{8{be[1]}}, {8{be[0]}}};
        end
    endfunction

    // hardware set beats software clear in the same cycle
    function [15:0] flag_next;
        input [15:0] cur;
        input [15:0] clr;
        input [15:0] set;
        input [15:0] msk;
        input [15:0] valid;
        begin
            flag_next = ((cur & ~clr) | (set & ~msk)) & valid;
        end
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    reg [15:0] system_events_reg;
    reg [15:0] clock_events_reg;
    reg [15:0] accessory_events_reg;
    reg [15:0] jack_clamp_events_reg;
    reg [15:0] system_mask_reg;
    reg [15:0] clock_mask_reg;
    reg [15:0] accessory_mask_reg;
    reg [15:0] jack_clamp_mask_reg;
    reg [1:0] control_reg;
    reg [31:0] readdata_reg;
    reg waitrequest_reg;
    reg irq_reg;
    reg pin_n_reg;
    reg acc_two_reg;
    reg acc_one_reg;

    reg [15:0] system_set_next;
    reg [15:0] clock_set_next;
    reg [15:0] accessory_set_next;
    reg [15:0] jack_clamp_set_next;
    reg [31:0] readdata_next;
    reg hit_next;

    wire [15:0] raw_levels;
    wire [15:0] lvl;
    wire [15:0] rise;
    wire [15:0] fall;
    wire [13:0] word_idx;
    wire write_commit;
    wire [15:0] wr_bits;
    wire [15:0] pending;
    wire irq_next;

    // ----------------------------------------------------------------
    // input sampling
    // ----------------------------------------------------------------
    // one slot per level, in the same order as the raw level word
    assign raw_levels = {
        clamp_two_in, clamp_one_in, jack_three_in, jack_two_in,
        jack_one_in, headphone_sense_in, loop_one_ref_missing_in,
        loop_two_ref_missing_in, loop_one_lock_in, loop_two_lock_in,
        main_clock_fault_in, second_clock_fault_in,
        processor_clock_fault_in, boot_complete_in,
        main_clock_fail_in, host_port_fault_in};

    level_edge_catch #(
        .WIDTH(16)
    ) u_edges (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .level_in(raw_levels),
        .level_out(lvl),
        .rise_out(rise),
        .fall_out(fall)
    );

    // detector strobes come from local logic; one flop registers them, one cycle
    // ahead of the edge strobes, without any synchroniser delay needed
    always @(posedge clk_sys_in) begin
        if (reset_in) begin
            acc_two_reg <= 1'b0;
            acc_one_reg <= 1'b0;
        end else begin
            acc_two_reg <= accessory_two_detect_in;
            acc_one_reg <= accessory_one_detect_in;
        end
    end

    // ----------------------------------------------------------------
    // event set vectors
    // ----------------------------------------------------------------
    always @* begin
        system_set_next = 16'h0000;
        clock_set_next = 16'h0000;
        accessory_set_next = 16'h0000;
        jack_clamp_set_next = 16'h0000;
        system_set_next[`BIT_HOST_PORT_FAULT] =
            rise[`LVL_HOST_PORT_FAULT];
        system_set_next[`BIT_MAIN_CLOCK_FAIL] =
            rise[`LVL_MAIN_CLOCK_FAIL];
        system_set_next[`BIT_BOOT_COMPLETE] =
            rise[`LVL_BOOT_COMPLETE];
        clock_set_next[`BIT_PROCESSOR_CLOCK_FAULT] =
            rise[`LVL_PROCESSOR_CLOCK_FAULT];
        clock_set_next[`BIT_SECOND_CLOCK_FAULT] =
            rise[`LVL_SECOND_CLOCK_FAULT];
        clock_set_next[`BIT_MAIN_CLOCK_FAULT] =
            rise[`LVL_MAIN_CLOCK_FAULT];
        clock_set_next[`BIT_LOOP_TWO_LOCK] =
            rise[`LVL_LOOP_TWO_LOCK] | fall[`LVL_LOOP_TWO_LOCK];
        clock_set_next[`BIT_LOOP_ONE_LOCK] =
            rise[`LVL_LOOP_ONE_LOCK] | fall[`LVL_LOOP_ONE_LOCK];
        clock_set_next[`BIT_LOOP_TWO_REF_MISSING] =
            rise[`LVL_LOOP_TWO_REF_MISSING];
        clock_set_next[`BIT_LOOP_ONE_REF_MISSING] =
            rise[`LVL_LOOP_ONE_REF_MISSING];
        accessory_set_next[`BIT_ACCESSORY_TWO_DETECT] = acc_two_reg;
        accessory_set_next[`BIT_ACCESSORY_ONE_DETECT] = acc_one_reg;
        accessory_set_next[`BIT_HEADPHONE_SENSE] =
            rise[`LVL_HEADPHONE_SENSE];
        jack_clamp_set_next[`BIT_JACK_ONE_RISE] =
            rise[`LVL_JACK_ONE];
        jack_clamp_set_next[`BIT_JACK_ONE_FALL] =
            fall[`LVL_JACK_ONE];
        jack_clamp_set_next[`BIT_JACK_TWO_RISE] =
            rise[`LVL_JACK_TWO];
        jack_clamp_set_next[`BIT_JACK_TWO_FALL] =
            fall[`LVL_JACK_TWO];
        jack_clamp_set_next[`BIT_JACK_THREE_RISE] =
            rise[`LVL_JACK_THREE];
        jack_clamp_set_next[`BIT_JACK_THREE_FALL] =
            fall[`LVL_JACK_THREE];
        jack_clamp_set_next[`BIT_CLAMP_ONE_RISE] =
            rise[`LVL_CLAMP_ONE];
        jack_clamp_set_next[`BIT_CLAMP_ONE_FALL] =
            fall[`LVL_CLAMP_ONE];
        jack_clamp_set_next[`BIT_CLAMP_TWO_RISE] =
            rise[`LVL_CLAMP_TWO];
        jack_clamp_set_next[`BIT_CLAMP_TWO_FALL] =
            fall[`LVL_CLAMP_TWO];
    end

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    // a write lands only at the edge where waitrequest is seen low
    assign word_idx = address_in[15:2];
    assign write_commit = write_in & ~waitrequest_reg;
    assign wr_bits = writedata_in[15:0] & lane_mask(byteenable_in);

    // read mux; unmapped words answer zero
    always @* begin
        readdata_next = 32'h00000000;
        hit_next = 1'b1;
        case (word_idx)
            `IDX_SYSTEM_EVENTS: readdata_next[15:0] = system_events_reg;
            `IDX_CLOCK_EVENTS: readdata_next[15:0] = clock_events_reg;
            `IDX_ACCESSORY_EVENTS: begin
                readdata_next[15:0] = accessory_events_reg;
            end
            `IDX_JACK_CLAMP_EVENTS: begin
                readdata_next[15:0] = jack_clamp_events_reg;
            end
            `IDX_SYSTEM_MASK: readdata_next[15:0] = system_mask_reg;
            `IDX_CLOCK_MASK: readdata_next[15:0] = clock_mask_reg;
            `IDX_ACCESSORY_MASK: readdata_next[15:0] = accessory_mask_reg;
            `IDX_JACK_CLAMP_MASK: begin
                readdata_next[15:0] = jack_clamp_mask_reg;
            end
            `IDX_RAW_LEVELS: readdata_next[15:0] = lvl;
            `IDX_REQUEST_CONTROL: readdata_next[1:0] = control_reg;
            default: hit_next = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // avalon handshake: one wait cycle, then a one-cycle answer
    // ----------------------------------------------------------------
    // waitrequest idles high so no request completes without decode
    always @(posedge clk_sys_in) begin
        if (reset_in) begin
            waitrequest_reg <= 1'b1;
            readdata_reg <= 32'h00000000;
        end else if (!waitrequest_reg) begin
            waitrequest_reg <= 1'b1;
        end else if (read_in || write_in) begin
            waitrequest_reg <= 1'b0;
            readdata_reg <= (read_in && hit_next) ?
                readdata_next : 32'h00000000;
        end
    end

    // ----------------------------------------------------------------
    // latched event words
    // ----------------------------------------------------------------
    always @(posedge clk_sys_in) begin
        if (reset_in) begin
            system_events_reg <= `EVENTS_RESET;
            clock_events_reg <= `EVENTS_RESET;
            accessory_events_reg <= `EVENTS_RESET;
            jack_clamp_events_reg <= `EVENTS_RESET;
        end else begin
            system_events_reg <= flag_next(system_events_reg,
                (write_commit && word_idx == `IDX_SYSTEM_EVENTS) ?
                wr_bits : 16'h0000, system_set_next,
                system_mask_reg, `SYSTEM_VALID);
            clock_events_reg <= flag_next(clock_events_reg,
                (write_commit && word_idx == `IDX_CLOCK_EVENTS) ?
                wr_bits : 16'h0000, clock_set_next,
                clock_mask_reg, `CLOCK_VALID);
            accessory_events_reg <= flag_next(accessory_events_reg,
                (write_commit && word_idx == `IDX_ACCESSORY_EVENTS) ?
                wr_bits : 16'h0000, accessory_set_next,
                accessory_mask_reg, `ACCESSORY_VALID);
            jack_clamp_events_reg <= flag_next(jack_clamp_events_reg,
                (write_commit && word_idx == `IDX_JACK_CLAMP_EVENTS) ?
                wr_bits : 16'h0000, jack_clamp_set_next,
                jack_clamp_mask_reg, `JACK_CLAMP_VALID);
        end
    end

    // ----------------------------------------------------------------
    // masks and request control
    // ----------------------------------------------------------------
    // byte lanes not enabled keep their old mask bits
    always @(posedge clk_sys_in) begin
        if (reset_in) begin
            system_mask_reg <= `SYSTEM_MASK_RESET;
            clock_mask_reg <= `CLOCK_MASK_RESET;
            accessory_mask_reg <= `ACCESSORY_MASK_RESET;
            jack_clamp_mask_reg <= `JACK_CLAMP_MASK_RESET;
            control_reg <= `CONTROL_RESET;
        end else if (write_commit) begin
            case (word_idx)
                `IDX_SYSTEM_MASK: begin
                    system_mask_reg <= ((system_mask_reg &
                        ~lane_mask(byteenable_in)) | wr_bits) &
                        `SYSTEM_VALID;
                end
                `IDX_CLOCK_MASK: begin
                    clock_mask_reg <= ((clock_mask_reg &
                        ~lane_mask(byteenable_in)) | wr_bits) &
                        `CLOCK_VALID;
                end
                `IDX_ACCESSORY_MASK: begin
                    accessory_mask_reg <= ((accessory_mask_reg &
                        ~lane_mask(byteenable_in)) | wr_bits) &
                        `ACCESSORY_VALID;
                end
                `IDX_JACK_CLAMP_MASK: begin
                    jack_clamp_mask_reg <= ((jack_clamp_mask_reg &
                        ~lane_mask(byteenable_in)) | wr_bits) &
                        `JACK_CLAMP_VALID;
                end
                `IDX_REQUEST_CONTROL: begin
                    if (byteenable_in[0]) begin
                        control_reg <= writedata_in[1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // request outputs
    // ----------------------------------------------------------------
    // a flag unmasked later still counts; masking hides it again
    assign pending = (system_events_reg & ~system_mask_reg) |
        (clock_events_reg & ~clock_mask_reg) |
        (accessory_events_reg & ~accessory_mask_reg) |
        (jack_clamp_events_reg & ~jack_clamp_mask_reg);
    assign irq_next = (|pending) &
        ~control_reg[`CTRL_GLOBAL_MASK];

    // pin idles high after reset; polarity bit inverts it
    always @(posedge clk_sys_in) begin
        if (reset_in) begin
            irq_reg <= 1'b0;
            pin_n_reg <= 1'b1;
        end else begin
            irq_reg <= irq_next;
            pin_n_reg <= ~(irq_next ^
                control_reg[`CTRL_POLARITY]);
        end
    end

    assign irq_out = irq_reg;
    assign first_request_output_n_out = pin_n_reg;
    assign readdata_out = readdata_reg;
    assign waitrequest_out = waitrequest_reg;

endmodule // irq_one_flags

// ==== core/irq_one_map.vh ====
// register map, field positions and reset values of the irq one flag block
`ifndef IRQ_ONE_MAP_VH
`define IRQ_ONE_MAP_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_SYSTEM_EVENTS 14'h1800
`define IDX_CLOCK_EVENTS 14'h1801
`define IDX_ACCESSORY_EVENTS 14'h1805
`define IDX_JACK_CLAMP_EVENTS 14'h1806
`define IDX_SYSTEM_MASK 14'h1840
`define IDX_CLOCK_MASK 14'h1841
`define IDX_ACCESSORY_MASK 14'h1845
`define IDX_JACK_CLAMP_MASK 14'h1846
`define IDX_RAW_LEVELS 14'h1880
`define IDX_REQUEST_CONTROL 14'h1890

// ----------------------------------------------------------------
// implemented bits of each event word, and mask reset values
// ----------------------------------------------------------------
`define SYSTEM_VALID 16'h1280
`define CLOCK_VALID 16'h7360
`define ACCESSORY_VALID 16'h0301
`define JACK_CLAMP_VALID 16'h0F3F
`define SYSTEM_MASK_RESET 16'h1200
`define CLOCK_MASK_RESET 16'h7360
`define ACCESSORY_MASK_RESET 16'h0301
`define JACK_CLAMP_MASK_RESET 16'h0F3F
`define EVENTS_RESET 16'h0000
`define CONTROL_RESET 2'h0

// ----------------------------------------------------------------
// event bit positions
// ----------------------------------------------------------------
`define BIT_HOST_PORT_FAULT 12
`define BIT_MAIN_CLOCK_FAIL 9
`define BIT_BOOT_COMPLETE 7
`define BIT_PROCESSOR_CLOCK_FAULT 14
`define BIT_SECOND_CLOCK_FAULT 13
`define BIT_MAIN_CLOCK_FAULT 12
`define BIT_LOOP_TWO_LOCK 9
`define BIT_LOOP_ONE_LOCK 8
`define BIT_LOOP_TWO_REF_MISSING 6
`define BIT_LOOP_ONE_REF_MISSING 5
`define BIT_ACCESSORY_TWO_DETECT 9
`define BIT_ACCESSORY_ONE_DETECT 8
`define BIT_HEADPHONE_SENSE 0
`define BIT_JACK_ONE_RISE 0
`define BIT_JACK_ONE_FALL 1
`define BIT_JACK_TWO_RISE 2
`define BIT_JACK_TWO_FALL 3
`define BIT_CLAMP_ONE_RISE 4
`define BIT_CLAMP_ONE_FALL 5
`define BIT_JACK_THREE_RISE 8
`define BIT_JACK_THREE_FALL 9
`define BIT_CLAMP_TWO_RISE 10
`define BIT_CLAMP_TWO_FALL 11

// ----------------------------------------------------------------
// request control fields and synchronised level positions
// ----------------------------------------------------------------
`define CTRL_POLARITY 0
`define CTRL_GLOBAL_MASK 1
`define LEVEL_COUNT 15
`define LVL_HOST_PORT_FAULT 0
`define LVL_MAIN_CLOCK_FAIL 1
`define LVL_BOOT_COMPLETE 2
`define LVL_PROCESSOR_CLOCK_FAULT 3
`define LVL_SECOND_CLOCK_FAULT 4
`define LVL_MAIN_CLOCK_FAULT 5
`define LVL_LOOP_TWO_LOCK 6
`define LVL_LOOP_ONE_LOCK 7
`define LVL_LOOP_TWO_REF_MISSING 8
`define LVL_LOOP_ONE_REF_MISSING 9
`define LVL_HEADPHONE_SENSE 10
`define LVL_JACK_ONE 11
`define LVL_JACK_TWO 12
`define LVL_JACK_THREE 13
`define LVL_CLAMP_ONE 14
`define LVL_CLAMP_TWO 15
`define ARM_DONE 2'h3

`endif

// ==== core/level_edge_catch.v ====
// two-stage synchroniser with rising and falling edge detection
`timescale 1ns/1ps
`include "irq_one_map.vh"

module level_edge_catch #(
    parameter WIDTH = 16
) (
    // clock and reset
    input wire clk_sys_in,
    input wire reset_in,
    // raw levels from outside the clock domain
    input wire [WIDTH-1:0] level_in,
    // synchronised level and edge strobes
    output wire [WIDTH-1:0] level_out,
    output wire [WIDTH-1:0] rise_out,
    output wire [WIDTH-1:0] fall_out
);

    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;
    reg [WIDTH-1:0] prev_reg;
    reg [1:0] arm_reg;

    // ----------------------------------------------------------------
    // sampling chain
    // ----------------------------------------------------------------
    // meta_reg feeds sync_reg only; edges compare the two later stages
    always @(posedge clk_sys_in) begin
        if (reset_in) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_reg <= {WIDTH{1'b0}};
            prev_reg <= {WIDTH{1'b0}};
            arm_reg <= 2'h0;
        end else begin
            meta_reg <= level_in;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
            if (arm_reg != `ARM_DONE) begin
                arm_reg <= arm_reg + 2'h1;
            end
        end
    end

    // edges held off until the chain is full, so a level high at
    // reset release does not look like a fresh edge
    assign level_out = sync_reg;
    assign rise_out = (arm_reg == `ARM_DONE) ?
        (sync_reg & ~prev_reg) : {WIDTH{1'b0}};
    assign fall_out = (arm_reg == `ARM_DONE) ?
        (~sync_reg & prev_reg) : {WIDTH{1'b0}};

endmodule // level_edge_catch

// ==== sim/first_request_output_latched_event_flags_tb.sv ====
// self-checking bench for the first request latched event flags
`timescale 1ns/1ps
module first_request_output_latched_event_flags_tb;
    logic clk_sys_in, reset_in, read_w, write_w, wait_w, irq_w, pin_w;
    logic acc_two, acc_one;
    logic [15:0] address_w, lv, rd;
    logic [31:0] wdata_w, rdata_w;
    logic [3:0] be_w;
    logic [13:0] ix;
    int i, error_cnt = 0, compares = 0;
    // ------------------------------------------------------------
    // rows: reset words, then level bit, rise word and fall word
    // ------------------------------------------------------------
    logic [13:0] ri[9] = '{14'h1800, 14'h1801, 14'h1805, 14'h1806,
        14'h1840, 14'h1841, 14'h1845, 14'h1846, 14'h1900};
    logic [15:0] rv[9] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h1200,
        16'h7360, 16'h0301, 16'h0F3F, 16'h0};
    int lb[15] = '{0, 1, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15};
    logic [15:0] tr[15] = '{16'h1000, 16'h0200, 16'h4000, 16'h2000,
        16'h1000, 16'h0200, 16'h0100, 16'h0040, 16'h0020, 16'h0001,
        16'h0001, 16'h0004, 16'h0100, 16'h0010, 16'h0400};
    logic [15:0] tf[15] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0200,
        16'h0100, 16'h0, 16'h0, 16'h0, 16'h0002, 16'h0008, 16'h0200,
        16'h0020, 16'h0800};
    irq_one_host host (.clk_sys_in(clk_sys_in), .address_out(address_w),
        .read_out(read_w), .write_out(write_w), .byteenable_out(be_w),
        .writedata_out(wdata_w), .readdata_in(rdata_w),
        .waitrequest_in(wait_w));
    irq_one_flags DUT (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
        .address_in(address_w), .read_in(read_w), .write_in(write_w),
        .byteenable_in(be_w), .writedata_in(wdata_w),
        .readdata_out(rdata_w), .waitrequest_out(wait_w),
        .host_port_fault_in(lv[0]), .main_clock_fail_in(lv[1]),
        .boot_complete_in(lv[2]), .processor_clock_fault_in(lv[3]),
        .second_clock_fault_in(lv[4]), .main_clock_fault_in(lv[5]),
        .loop_two_lock_in(lv[6]), .loop_one_lock_in(lv[7]),
        .loop_two_ref_missing_in(lv[8]), .loop_one_ref_missing_in(lv[9]),
        .accessory_two_detect_in(acc_two), .accessory_one_detect_in(acc_one),
        .headphone_sense_in(lv[10]), .jack_one_in(lv[11]),
        .jack_two_in(lv[12]), .jack_three_in(lv[13]), .clamp_one_in(lv[14]),
        .clamp_two_in(lv[15]), .irq_out(irq_w),
        .first_request_output_n_out(pin_w));
    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    task automatic print_verdict;
        if (error_cnt == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic fail(input string m);
        error_cnt++;
        $display("mismatch at %0t: %s", $time, m);
    endtask
    // a hung bus ends the run at once
    task automatic bus(input logic wr, input logic [13:0] a,
        input logic [15:0] d);
        logic ok;
        host.xfer(wr, a, d, rd, ok);
        if (!ok) begin
            fail("bus timeout");
            print_verdict();
        end
    endtask
    task automatic chk(input logic [13:0] a, input logic [15:0] e);
        bus(1'b0, a, 16'h0);
        compares++;
        if (rd !== e) fail($sformatf("word %h read %h want %h", a, rd, e));
    endtask
    task automatic req(input logic e);
        compares++;
        if (irq_w !== e || pin_w !== !e) fail("request pins wrong");
    endtask
    // read, compare, and if set clear it and see the request fall
    task automatic edge_chk(input logic [13:0] a, input logic [15:0] e);
        chk(a, e);
        req(e != 16'h0);
        if (e != 16'h0) begin
            bus(1'b1, a, 16'hFFFF);
            chk(a, 16'h0);
            req(1'b0);
        end
    endtask
    task automatic settle;
        repeat (6) @(posedge clk_sys_in);
    endtask
    initial begin
        reset_in = 1'b1;
        lv = 16'h0;
        acc_two = 1'b0;
        acc_one = 1'b0;
        repeat (3) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        settle();
        for (i = 0; i < 9; i++) chk(ri[i], rv[i]);
        lv[11] <= 1'b1;
        settle();
        edge_chk(14'h1806, 16'h0);
        lv[11] <= 1'b0;
        lv[2] <= 1'b1;
        settle();
        edge_chk(14'h1800, 16'h0080);
        chk(14'h1880, 16'h0004);
        for (i = 4; i < 8; i++) bus(1'b1, ri[i], 16'h0);
        for (i = 0; i < 15; i++) begin
            ix = lb[i] < 2 ? 14'h1800 : lb[i] < 10 ? 14'h1801 :
                lb[i] == 10 ? 14'h1805 : 14'h1806;
            lv[lb[i]] <= 1'b1;
            settle();
            edge_chk(ix, tr[i]);
            lv[lb[i]] <= 1'b0;
            settle();
            edge_chk(ix, tf[i]);
        end
        // detector pulses; a zero write must leave the flag alone
        acc_two <= 1'b1;
        @(posedge clk_sys_in);
        acc_two <= 1'b0;
        settle();
        bus(1'b1, 14'h1805, 16'h0);
        // global mask hides the pending flag without clearing it
        bus(1'b1, 14'h1890, 16'h0002);
        settle();
        req(1'b0);
        bus(1'b1, 14'h1890, 16'h0000);
        settle();
        edge_chk(14'h1805, 16'h0200);
        acc_one <= 1'b1;
        @(posedge clk_sys_in);
        acc_one <= 1'b0;
        settle();
        edge_chk(14'h1805, 16'h0100);
        print_verdict();
    end
endmodule // first_request_output_latched_event_flags_tb

// ==== sim/irq_one_flags_sva.sv ====
// assertions on the bus handshake and request pins of the flag block
`timescale 1ns/1ps
module irq_one_flags_chk (
    // clock and reset
    input wire clk_sys_in,
    input wire reset_in,
    // bus and request pins
    input wire read_in,
    input wire write_in,
    input wire [31:0] readdata_out,
    input wire waitrequest_out,
    input wire irq_out,
    input wire first_request_output_n_out
);
    // ------------------------------------------------------------
    // handshake steps and flag holding
    // ------------------------------------------------------------
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    wire commit = write_in && !waitrequest_out;
    sequence taken_s;
        (read_in || write_in) && waitrequest_out;
    endsequence
    // a clear needs two edges to reach the request, so skip both
    sequence held_s;
        irq_out && !commit && !$past(commit);
    endsequence
    wait_answer_a: assert property (taken_s |=> !waitrequest_out)
        else $error("request not answered next cycle");
    wait_pulse_a: assert property ($fell(waitrequest_out) |=> waitrequest_out)
        else $error("wait low for more than one cycle");
    idle_wait_a: assert property
        (!read_in && !write_in && waitrequest_out |=> waitrequest_out)
        else $error("answer without request");
    read_hold_a: assert property
        (waitrequest_out && $past(waitrequest_out) |-> $stable(readdata_out))
        else $error("read data moved between accesses");
    flag_sticky_a: assert property (held_s |=> irq_out)
        else $error("request dropped without a clear");
    pin_polarity_a: assert property
        (first_request_output_n_out == !irq_out)
        else $error("pin not the inverse of the request");
    reset_quiet_a: assert property ($past(reset_in) |->
        waitrequest_out && !irq_out && first_request_output_n_out)
        else $error("outputs not at rest after reset");
    boot_quiet_a: assert property ($fell(reset_in) |-> !irq_out [*4])
        else $error("request too soon after reset");
endmodule // irq_one_flags_chk
bind irq_one_flags irq_one_flags_chk chk (.clk_sys_in(clk_sys_in),
    .reset_in(reset_in), .read_in(read_in), .write_in(write_in),
    .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
    .irq_out(irq_out),
    .first_request_output_n_out(first_request_output_n_out));

// ==== sim/irq_one_host.sv ====
// host model: avalon master that polls and clears the flag words
`timescale 1ns/1ps
module irq_one_host (
    // clock
    input wire clk_sys_in,
    // avalon master side
    output logic [15:0] address_out,
    output logic read_out,
    output logic write_out,
    output logic [3:0] byteenable_out,
    output logic [31:0] writedata_out,
    input wire [31:0] readdata_in,
    input wire waitrequest_in
);
    initial begin
        address_out = 16'h0000;
        read_out = 1'b0;
        write_out = 1'b0;
        byteenable_out = 4'h3;
        writedata_out = 32'h00000000;
    end
    // one transfer; ok stays low if the slave never answers
    task automatic xfer(input logic wr, input logic [13:0] idx,
        input logic [15:0] wd, output logic [15:0] rd, output logic ok);
        int n;
        ok = 1'b0;
        rd = 16'h0000;
        @(posedge clk_sys_in);
        address_out <= {idx, 2'b00};
        writedata_out <= {16'h0000, wd};
        read_out <= !wr;
        write_out <= wr;
        for (n = 0; n < 64 && !ok; n++) begin
            @(posedge clk_sys_in);
            if (waitrequest_in === 1'b0) begin
                ok = 1'b1;
                rd = readdata_in[15:0];
            end
        end
        // released data is scrambled so nothing relies on stale lanes
        read_out <= 1'b0;
        write_out <= 1'b0;
        writedata_out <= ~writedata_out;
    endtask
endmodule // irq_one_host
